/* File: design/cell_balance_map.vh */
/*
 * Register offsets, field positions and reset values for the cell-balancing
 * measurement and calibration scheduler.
 * Assumes inclusion by bare name from the scheduler design file.
 */
`ifndef CELL_BALANCE_MAP_VH
`define CELL_BALANCE_MAP_VH

// ============================================================
// Register byte offsets
`define OFS_BAL_CTRL      8'h00
`define OFS_CAL_DLY       8'h04
`define OFS_UV_THR        8'h08
`define OFS_SCAN_CFG      8'h0c
`define OFS_BAL_DATA      8'h10
`define OFS_BAL_STATUS    8'h14
`define OFS_CELL_BASE     8'h40

// ============================================================
// Control register fields
`define CTRL_MODE_LSB     0
`define CTRL_MEAS_LSB     4
`define CTRL_IIRINIT_BIT  6
`define CTRL_CALAPP_BIT   7
`define CTRL_COEF_LSB     8

// ============================================================
// Status register fields
`define STAT_REJECT_BIT   0
`define STAT_CALFLT_BIT   1
`define STAT_ACTIVE_BIT   2
`define STAT_BUSY_BIT     3
`define STAT_UV_LSB       16

// ============================================================
// Balancing modes and codes
`define MODE_OFF          3'h0
`define MODE_MANUAL       3'h1
`define MODE_DISCHARGE    3'h2
`define COEF_BYPASS       3'h7
`define COEF_DEBOUNCE     3'h0
`define OVSAMPLE_16X      3'h4
`define SCAN_PYRAMID      1'b1
`define CALSEL_FACTORY    2'h0
`define CALSEL_PRIOR      2'h1
`define CALSEL_PERIODIC   2'h2
`define INIT_SETTLE_MEAS  5'h10

// ============================================================
// Reset values
`define RST_CTRL          11'h000
`define RST_CAL_DLY       3'h0
`define RST_UV_THR        14'h0000
`define RST_SCAN_CFG      16'h0000

`endif

/* File: design/cell_balance_measure_cal_sched.v */
/*
 * Cell-balancing measurement and calibration scheduler with APB registers,
 * per-cell IIR filters, undervoltage checks and calibration-fault halt.
 * Assumes a switch sequencer that pulses pair_done after each even/odd pair,
 * an ADC engine that streams per-cell results then pulses adc_done, and an
 * external balancing timer that reports expiry.
 */
// Notes on behaviour
// - Measurement enable acts only in discharge/automated modes
// - Oversampling forced 16x, pyramid scan order
// - Scan writes during balancing dropped, alert raised
// - Automated measurements pass through the cell's IIR
// - Bypass coefficient replaced by one eighth
// - Init clear: accumulators kept on entry
// - Init set: first measurement loads accumulators
// - Init mode: UV checks start at 17th
// - One measurement after each even/odd pair
// - Enable field: 0x none, 1x measure, 11 UV (automated modes only)
// - Calibration-apply selects coefficient source
// - Calibration interval needs measurements enabled
// - Interval zero means no calibrations
// - First operation calibrates, then periodic replacement
// - Interval codes give 2..32 cycle period
// - Calibration-apply on: check calibration range after every operation
// - Out of range: fault alert, halt switches
// - After fault skip everything until expiry/restart
// - Timer keeps running after fault
// - Strobe copies IIR to cell registers in active discharge/automated modes, reads zero
// - Strobe during sequence deferred until completion
// - UV threshold 14 bits, 305uV per step
// - UV crossing stops that cell until restart
`include "cell_balance_map.vh"

module cell_balance_measure_cal_sched #(
	parameter N_CELLS = 14,
	parameter DATA_W  = 14
) (
	input  wire                pclk,
	input  wire                presetn,
	input  wire                psel,
	input  wire                penable,
	input  wire                pwrite,
	input  wire [7:0]          paddr,
	input  wire [31:0]         pwdata,
	output wire                pready,
	output reg  [31:0]         prdata,
	output wire                pslverr,
	input  wire                pair_done,
	input  wire                timer_expired,
	output reg                 adc_start,
	output reg                 adc_cal_op,
	output wire [2:0]          adc_oversample,
	output wire                adc_scan_order,
	output wire [15:0]         scan_config,
	input  wire                adc_result_valid,
	input  wire [3:0]          adc_result_cell,
	input  wire [DATA_W-1:0]   adc_result_data,
	input  wire                adc_done,
	input  wire                calibration_range_alert,
	output reg  [1:0]          cal_coef_select,
	output wire                balance_halt,
	output wire [N_CELLS-1:0]  uv_cell_stop
);

	localparam ACC_W = DATA_W + 3;

	// ============================================================
	// Register storage
	reg  [10:0]          ctrl_q;
	reg  [2:0]           cal_dly_q;
	reg  [DATA_W-1:0]    uv_thr_q;
	reg  [15:0]          scan_cfg_q;
	reg                  reject_q;
	reg                  fault_q;
	reg                  busy_q;
	reg                  xfer_pend_q;
	reg                  load_first_q;
	reg  [4:0]           meas_num_q;
	reg  [4:0]           cal_cnt_q;
	reg  [N_CELLS-1:0]   uv_stat_q;
	reg  [ACC_W-1:0]     acc_q  [0:N_CELLS-1];
	reg  [DATA_W-1:0]    cell_q [0:N_CELLS-1];

	// ============================================================
	// Field decode
	wire [2:0] mode        = ctrl_q[`CTRL_MODE_LSB+2:`CTRL_MODE_LSB];
	wire [1:0] balance_measure_enable = ctrl_q[`CTRL_MEAS_LSB+1:`CTRL_MEAS_LSB];
	wire       iir_init_on_entry      = ctrl_q[`CTRL_IIRINIT_BIT];
	wire       calibration_apply_enable = ctrl_q[`CTRL_CALAPP_BIT];
	wire [2:0] iir_coefficient        = ctrl_q[`CTRL_COEF_LSB+2:`CTRL_COEF_LSB];

	wire is_auto      = mode[2];
	wire is_discharge = (mode == `MODE_DISCHARGE);
	wire bal_active   = (mode != `MODE_OFF) && !timer_expired;
	wire meas_mode    = bal_active && (is_auto || is_discharge);
	wire meas_on      = meas_mode && balance_measure_enable[1];
	wire uv_enable    = is_auto && (balance_measure_enable == 2'b11);

	// Interval counts only when measurements run; zero disables calibrations
	wire [2:0] cal_code = balance_measure_enable[1] ? cal_dly_q : 3'h0;
	wire       cal_on   = (cal_code != 3'h0);

	// Calibration period decode, in operation cycles
	function [5:0] cal_period;
		input [2:0] code;
		begin
			case (code)
				3'h1: cal_period = 6'd2;
				3'h2: cal_period = 6'd4;
				3'h3: cal_period = 6'd8;
				3'h4: cal_period = 6'd12;
				3'h5: cal_period = 6'd16;
				3'h6: cal_period = 6'd24;
				3'h7: cal_period = 6'd32;
				default: cal_period = 6'd1;
			endcase
		end
	endfunction

	wire [5:0] period_n  = cal_period(cal_code);
	wire       cnt_wrap  = ({1'b0, cal_cnt_q} == period_n - 6'd1);

	// ============================================================
	// APB decode
	wire apb_setup = psel && !penable;
	wire apb_wr    = psel && penable && pwrite;
	wire is_cell   = (paddr[7:6] == 2'b01) && (paddr[5:2] < N_CELLS);
	wire mapped    = (paddr == `OFS_BAL_CTRL) || (paddr == `OFS_CAL_DLY) ||
	                 (paddr == `OFS_UV_THR) || (paddr == `OFS_SCAN_CFG) ||
	                 (paddr == `OFS_BAL_DATA) || (paddr == `OFS_BAL_STATUS) || is_cell;
	wire wr_ctrl   = apb_wr && (paddr == `OFS_BAL_CTRL);
	wire wr_scan   = apb_wr && (paddr == `OFS_SCAN_CFG);
	wire wr_status = apb_wr && (paddr == `OFS_BAL_STATUS);
	wire strobe    = apb_wr && (paddr == `OFS_BAL_DATA) && pwdata[0];

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// Fixed scan parameters during balancing measurements
	assign adc_oversample = `OVSAMPLE_16X;
	assign adc_scan_order = `SCAN_PYRAMID;
	assign scan_config    = scan_cfg_q;

	// Switch halt and per-cell stop
	assign balance_halt = fault_q;
	assign uv_cell_stop = uv_stat_q;

	// ============================================================
	// Sequencer events
	wire entry     = wr_ctrl && (pwdata[`CTRL_MODE_LSB+2:`CTRL_MODE_LSB] != `MODE_OFF);
	wire start_op  = pair_done && meas_on && !fault_q && !busy_q;
	wire start_cal = cal_on && (cal_cnt_q == 5'h0);
	wire op_end    = busy_q && adc_done;
	wire cal_bad   = op_end && calibration_apply_enable &&
	                 calibration_range_alert;
	wire meas_res  = busy_q && !adc_cal_op && adc_result_valid &&
	                 (adc_result_cell < N_CELLS);
	wire do_copy   = meas_mode && ((strobe && !busy_q) ||
	                 ((xfer_pend_q || strobe) && op_end));

	// ============================================================
	// IIR datapath for the incoming cell
	wire [2:0]         coef_eff = (iir_coefficient == `COEF_BYPASS) ?
	                              `COEF_DEBOUNCE : iir_coefficient;
	wire [3:0]         weight   = {1'b0, coef_eff} + 4'h1;
	wire [ACC_W-1:0]   acc_cur  = acc_q[adc_result_cell];
	wire signed [ACC_W:0] diff  = $signed({1'b0, adc_result_data, 3'b000}) -
	                              $signed({1'b0, acc_cur});
	wire signed [ACC_W+5:0] prod = diff * $signed({1'b0, weight});
	wire signed [ACC_W+2:0] sum  = $signed({3'b000, acc_cur}) +
	                               $signed(prod[ACC_W+5:3]);
	wire [ACC_W-1:0]   acc_new  = load_first_q ? {adc_result_data, 3'b000} :
	                              sum[ACC_W-1:0];
	wire               uv_ok    = !iir_init_on_entry ||
	                              (meas_num_q >= `INIT_SETTLE_MEAS);
	wire               uv_hit   = meas_res && uv_enable && uv_ok &&
	                              (acc_new[ACC_W-1:3] < uv_thr_q);

	// ============================================================
	// Register writes and alerts
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q     <= `RST_CTRL;
			cal_dly_q  <= `RST_CAL_DLY;
			uv_thr_q   <= `RST_UV_THR;
			scan_cfg_q <= `RST_SCAN_CFG;
			reject_q   <= 1'b0;
		end else begin
			if (wr_ctrl)
				ctrl_q <= pwdata[10:0];
			if (apb_wr && (paddr == `OFS_CAL_DLY))
				cal_dly_q <= pwdata[2:0];
			if (apb_wr && (paddr == `OFS_UV_THR))
				uv_thr_q <= pwdata[DATA_W-1:0];
			if (wr_scan && !bal_active)
				scan_cfg_q <= pwdata[15:0];
			// Rejected scan write sets the alert; set wins over clear
			if (wr_scan && bal_active)
				reject_q <= 1'b1;
			else if (wr_status && pwdata[`STAT_REJECT_BIT])
				reject_q <= 1'b0;
		end
	end

	// ============================================================
	// Measurement and calibration scheduling
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q       <= 1'b0;
			adc_start    <= 1'b0;
			adc_cal_op   <= 1'b0;
			fault_q      <= 1'b0;
			load_first_q <= 1'b0;
			meas_num_q   <= 5'h0;
			cal_cnt_q    <= 5'h0;
			uv_stat_q    <= {N_CELLS{1'b0}};
			xfer_pend_q  <= 1'b0;
		end else begin
			adc_start <= start_op;
			if (wr_ctrl) begin
				// Abort or restart clears fault, UV exits and sequence state
				busy_q       <= 1'b0;
				fault_q      <= 1'b0;
				uv_stat_q    <= {N_CELLS{1'b0}};
				load_first_q <= entry && pwdata[`CTRL_IIRINIT_BIT];
				meas_num_q   <= 5'h0;
				cal_cnt_q    <= 5'h0;
				xfer_pend_q  <= 1'b0;
			end else begin
				if (start_op) begin
					busy_q     <= 1'b1;
					adc_cal_op <= start_cal;
					cal_cnt_q  <= (!cal_on || cnt_wrap) ? 5'h0 : cal_cnt_q + 5'h1;
				end
				if (op_end) begin
					busy_q <= 1'b0;
					if (!adc_cal_op) begin
						load_first_q <= 1'b0;
						if (meas_num_q != 5'h1f)
							meas_num_q <= meas_num_q + 5'h1;
					end
				end
				// Fault holds while the external timer runs on to expiry
				if (cal_bad)
					fault_q <= 1'b1;
				if (uv_hit)
					uv_stat_q[adc_result_cell] <= 1'b1;
				if (strobe && busy_q && !op_end && meas_mode)
					xfer_pend_q <= 1'b1;
				else if (do_copy || !meas_mode)
					xfer_pend_q <= 1'b0;
			end
		end
	end

	// Coefficient source for ADC correction
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cal_coef_select <= `CALSEL_FACTORY;
		else if (!calibration_apply_enable)
			cal_coef_select <= `CALSEL_FACTORY;
		else if (cal_on)
			cal_coef_select <= `CALSEL_PERIODIC;
		else
			cal_coef_select <= `CALSEL_PRIOR;
	end

	// ============================================================
	// Per-cell accumulators and result registers
	genvar gi;
	generate
		for (gi = 0; gi < N_CELLS; gi = gi + 1) begin : g_cell
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					acc_q[gi]  <= {ACC_W{1'b0}};
					cell_q[gi] <= {DATA_W{1'b0}};
				end else begin
					if (meas_res && (adc_result_cell == gi))
						acc_q[gi] <= acc_new;
					if (do_copy)
						cell_q[gi] <= acc_q[gi][ACC_W-1:3];
				end
			end
		end
	endgenerate

	// ============================================================
	// Read data, captured in the setup phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (apb_setup) begin
			prdata <= 32'h00000000;
			case (paddr)
				`OFS_BAL_CTRL:   prdata[10:0] <= ctrl_q;
				`OFS_CAL_DLY:    prdata[2:0] <= cal_dly_q;
				`OFS_UV_THR:     prdata[DATA_W-1:0] <= uv_thr_q;
				`OFS_SCAN_CFG:   prdata[15:0] <= scan_cfg_q;
				`OFS_BAL_DATA:   prdata <= 32'h00000000;
				`OFS_BAL_STATUS: begin
					prdata[`STAT_REJECT_BIT] <= reject_q;
					prdata[`STAT_CALFLT_BIT] <= fault_q;
					prdata[`STAT_ACTIVE_BIT] <= bal_active;
					prdata[`STAT_BUSY_BIT]   <= busy_q;
					prdata[`STAT_UV_LSB+N_CELLS-1:`STAT_UV_LSB] <= uv_stat_q;
				end
				default: begin
					if (is_cell)
						prdata[DATA_W-1:0] <= cell_q[paddr[5:2]];
				end
			endcase
		end
	end

endmodule

/* File: tb/sched_sva.sv */
/*
 * Port checker for the balancing measurement and calibration scheduler.
 * Assumes binding to every scheduler instance, one clock, async low reset.
 */
module sched_sva #(
	parameter N_CELLS = 14
) (
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [7:0]         paddr,
	input wire logic               pair_done,
	input wire logic               adc_start,
	input wire logic               adc_cal_op,
	input wire logic [2:0]         adc_oversample,
	input wire logic               adc_scan_order,
	input wire logic               adc_result_valid,
	input wire logic               adc_done,
	input wire logic               calibration_range_alert,
	input wire logic [1:0]         cal_coef_select,
	input wire logic               balance_halt,
	input wire logic [N_CELLS-1:0] uv_cell_stop
);
	timeunit 1ns;
	timeprecision 1ps;

	// ============================================================
	// Helpers
	wire ctrl_wr = psel && penable && pwrite && paddr == 8'h00;
	wire cfg_wr  = psel && penable && pwrite && (paddr == 8'h00 || paddr == 8'h04);

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ============================================================
	// Properties
	fixed_scan_a: assert property (adc_oversample == 3'h4 && adc_scan_order)
		else $error("scan setup not fixed");
	start_cause_a: assert property (
		adc_start |-> $past(pair_done) && !$past(balance_halt))
		else $error("start without pair end");
	calop_steady_a: assert property (
		adc_start ##1 !adc_done |-> $stable(adc_cal_op))
		else $error("operation kind changed");
	coef_src_a: assert property (cal_coef_select != 2'h3)
		else $error("bad coefficient source");
	coef_change_a: assert property (
		$changed(cal_coef_select) |-> $past(cfg_wr, 2))
		else $error("coefficient source changed without a write");
	halt_cause_a: assert property (
		$rose(balance_halt) |-> $past(adc_done && calibration_range_alert))
		else $error("halt without range alert");
	halt_skip_a: assert property (balance_halt |-> !adc_start)
		else $error("operation after fault");
	halt_hold_a: assert property (balance_halt && !ctrl_wr |=> balance_halt)
		else $error("fault dropped");
	uv_cause_a: assert property (
		(uv_cell_stop & ~$past(uv_cell_stop)) != 0 |-> $past(adc_result_valid))
		else $error("uv flag without result");
	uv_hold_a: assert property (
		!ctrl_wr |=> (uv_cell_stop & $past(uv_cell_stop)) == $past(uv_cell_stop))
		else $error("uv flag dropped");
endmodule

bind cell_balance_measure_cal_sched sched_sva #(.N_CELLS(N_CELLS)) sva_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pair_done(pair_done), .adc_start(adc_start), .adc_cal_op(adc_cal_op),
	.adc_oversample(adc_oversample), .adc_scan_order(adc_scan_order),
	.adc_result_valid(adc_result_valid), .adc_done(adc_done),
	.calibration_range_alert(calibration_range_alert), .cal_coef_select(cal_coef_select),
	.balance_halt(balance_halt), .uv_cell_stop(uv_cell_stop));

/* File: tb/adc_model.sv */
/*
 * ADC engine model: on each start streams one result per cell, then ends.
 * Assumes the bench sets the cell level; data line scrambled when idle.
 */
module adc_model (
	input  wire logic        pclk,
	input  wire logic        adc_start,
	input  wire logic [13:0] level,
	output logic             rv,
	output logic [3:0]       rc,
	output logic [13:0]      rd,
	output logic             done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       busy = 1'b0;
	logic [4:0] n = 5'h00;

	// ============================================================
	// Result stream, then end pulse
	initial begin
		{rv, done, rc, rd} = '0;
	end
	always @(posedge pclk) begin
		done <= 1'b0;
		rv <= 1'b0;
		rd <= ~rd;
		if (adc_start) begin
			busy <= 1'b1;
			n <= 5'h00;
		end else if (busy && n < 5'h0e) begin
			rv <= 1'b1;
			rc <= n[3:0];
			rd <= level;
			n <= n + 5'h01;
		end else if (busy) begin
			done <= 1'b1;
			busy <= 1'b0;
		end
	end
endmodule

/* File: tb/tb_top.sv */
/*
 * Self-checking bench for the balancing scheduler.
 * Assumes APB with zero wait states and the ADC model as far side.
 */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, pair_done, cra, texp;
	logic        pready, pslverr, adc_start, adc_cal_op, halt, st, cal, err, rv, done;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [1:0]  csel;
	logic [3:0]  rc;
	logic [13:0] level, rd, uv;
	logic [15:0] scfg;
	logic [12:0] mtab[6] = '{13'h0021, 13'h0023, 13'h0012, 13'h0004, 13'h1022, 13'h1024};
	int          per[8] = '{1, 2, 4, 8, 12, 16, 24, 32};
	int          mismatches, tests_run, cyc, i, c, n;

	cell_balance_measure_cal_sched dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.pair_done(pair_done), .timer_expired(texp), .adc_start(adc_start),
		.adc_cal_op(adc_cal_op), .adc_oversample(), .adc_scan_order(), .scan_config(scfg),
		.adc_result_valid(rv), .adc_result_cell(rc), .adc_result_data(rd), .adc_done(done),
		.calibration_range_alert(cra), .cal_coef_select(csel), .balance_halt(halt),
		.uv_cell_stop(uv));
	adc_model adc (.pclk(pclk), .adc_start(adc_start), .level(level), .rv(rv), .rc(rc),
		.rd(rd), .done(done));

	// ============================================================
	// Clock and hang limit
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			mismatches++;
			give_verdict;
		end
	end

	// ============================================================
	// Tasks
	task give_verdict;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Pair end, then wait for a start and the end of the operation
	task op;
		pair_done <= 1'b1;
		@(posedge pclk);
		pair_done <= 1'b0;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (adc_start !== 1'b1 && n < 8);
		st = adc_start;
		cal = adc_cal_op;
		if (st) do @(posedge pclk); while (done !== 1'b1);
		@(posedge pclk);
	endtask

	// ============================================================
	// Test sequence
	initial begin
		{psel, penable, pwrite, pair_done, cra, texp, presetn} = '0;
		paddr = '0;
		pwdata = '0;
		level = 14'h1000;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, 8'h04, 0);
		chk("interval", q, 0);
		apb(0, 8'h20, 0);
		chk("unmapped", err, 1);
		apb(1, 8'h10, 1);
		apb(0, 8'h10, 0);
		chk("strobe", q, 0);
		foreach (mtab[k]) begin
			apb(1, 0, mtab[k][11:0]);
			op;
			chk("start", st, mtab[k][12]);
		end
		$display("test modes done");
		for (c = 0; c < 8; c++) begin
			apb(1, 8'h04, c);
			apb(1, 8'h00, 32'h24);
			for (i = 0; i < (c ? per[c] + 1 : 3); i++) begin
				op;
				chk("cal_op", cal, c != 0 && i % per[c] == 0);
			end
		end
		$display("test intervals done");
		apb(1, 8'h0c, 32'h1234);
		apb(0, 8'h0c, 0);
		chk("scan_cfg", q, 0);
		apb(0, 8'h14, 0);
		chk("reject", q[0], 1);
		apb(1, 8'h04, 0);
		apb(1, 8'h08, 32'h1001);
		apb(1, 0, 32'h774);
		for (i = 1; i < 18; i++) begin
			op;
			chk("uv", uv, i == 17 ? 32'h3fff : 0);
		end
		apb(1, 8'h10, 1);
		apb(0, 8'h74, 0);
		chk("cell13", q, 32'h1000);
		level <= 14'h1800;
		apb(1, 0, 32'h724);
		op;
		apb(1, 8'h10, 1);
		apb(0, 8'h40, 0);
		chk("cell0", q, 32'h1100);
		// Strobe during an operation: copy waits for its end
		pair_done <= 1'b1;
		@(posedge pclk);
		pair_done <= 1'b0;
		apb(1, 8'h10, 1);
		apb(0, 8'h40, 0);
		chk("deferred", q, 32'h1100);
		do @(posedge pclk); while (done !== 1'b1);
		@(posedge pclk);
		apb(0, 8'h40, 0);
		chk("copied", q, 32'h11e0);
		apb(1, 0, 0);
		apb(1, 8'h10, 1);
		apb(0, 8'h40, 0);
		chk("cell0_idle", q, 32'h11e0);
		$display("test filter done");
		apb(1, 0, 32'ha4);
		@(posedge pclk);
		chk("coef_src", csel, 1);
		apb(1, 0, 32'h24);
		@(posedge pclk);
		chk("coef_src", csel, 0);
		apb(1, 8'h04, 1);
		apb(1, 0, 32'ha4);
		@(posedge pclk);
		chk("coef_src", csel, 2);
		cra <= 1'b1;
		op;
		chk("halt", halt, 1);
		op;
		chk("skip", st, 0);
		apb(0, 8'h14, 0);
		chk("fault", q[1], 1);
		$display("test fault done");
		// Timer expiry ends the active window; scan writes accepted again
		texp <= 1'b1;
		apb(1, 8'h0c, 32'h1234);
		apb(0, 8'h0c, 0);
		chk("scan_idle", q, 32'h1234);
		chk("scan_out", scfg, 32'h1234);
		apb(0, 8'h14, 0);
		chk("expired", q[2:1], 2'b01);
		$display("test expiry done");
		give_verdict;
	end
endmodule
